// *** sim/cpu_model.sv ***
// Behavioural CPU that executes one sleep instruction per request count step.
// Assumes the controller's tick and halted outputs; requests come from the bench.
`timescale 1ns/1ps
module cpu_model (
	input  wire logic       sys_clk_in,
	input  wire logic       reset_n_in,
	input  wire logic       cpu_tick_in,
	input  wire logic       cpu_halted_in,
	input  wire logic [7:0] req_cnt_in,
	output logic            sleep_exec_out
);
	// ==========================================
	// Sleep issue
	logic [7:0] served;
	// A halted CPU executes nothing, so a sleep waits for a tick while running
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			served         <= 8'h00;
			sleep_exec_out <= 1'b0;
		end else if (!sleep_exec_out && req_cnt_in != served && cpu_tick_in && !cpu_halted_in) begin
			served         <= served + 8'h01;
			sleep_exec_out <= 1'b1;
		end else begin
			sleep_exec_out <= 1'b0;
		end
	end
endmodule

// *** sim/test_direct_mode_transfer_control.sv ***
// Self-checking bench: AHB-Lite register access plus CPU sleep requests.
// Assumes the design's hand-over timing; oscillator wait shortened to 64.
`timescale 1ns/1ps
module test_direct_mode_transfer_control;
	logic sys_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, wake = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  spd, spd_irq;
	logic [7:0]  req_cnt = 8'h00;
	logic        hreadyout, hresp, sleep_exec, halted, tick, dt_irq;
	int          n_fail = 0, checks_done = 0, cyc = 0, n_irq = 0, irq_t, sleep_t, last_t, gap;
	always #50 sys_clk = ~sys_clk;
	direct_mode_transfer_control #(.OSC_WAIT_STATES(64)) DUT (.sys_clk_in(sys_clk),
		.reset_n_in(reset_n), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hreadyout), .hwdata_in(hwdata),
		.hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
		.sleep_exec_in(sleep_exec), .wake_irq_in(wake), .speed_mode_out(spd),
		.cpu_halted_out(halted), .cpu_tick_out(tick), .dt_irq_out(dt_irq));
	cpu_model cpu (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .cpu_tick_in(tick),
		.cpu_halted_in(halted), .req_cnt_in(req_cnt), .sleep_exec_out(sleep_exec));
	// ==========================================
	// Monitors
	always @(posedge sys_clk) begin
		cyc++;
		if (sleep_exec === 1'b1) sleep_t = cyc;
		if (tick === 1'b1) begin
			gap = cyc - last_t;
			last_t = cyc;
		end
		if (dt_irq === 1'b1) begin
			irq_t = cyc;
			spd_irq = spd;
			n_irq++;
		end
	end
	// ==========================================
	// Tasks
	task check(input bit ok, input string msg);
		checks_done++;
		if (!ok) begin
			n_fail++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		d = hrdata;
		check(hresp === 1'b0, "response not okay");
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		check(d === e, "register read value");
	endtask
	task sleep_n(input int n);
		req_cnt <= req_cnt + 8'h01;
		repeat (n) @(posedge sys_clk);
	endtask
	task trans(input logic [2:0] e_spd, input int lo, input int hi);
		int n0;
		int k;
		n0 = n_irq;
		k = 0;
		req_cnt <= req_cnt + 8'h01;
		while (n_irq == n0 && k < 3000) begin
			@(posedge sys_clk);
			k++;
		end
		check(k < 3000 && spd_irq === e_spd, "speed at transfer interrupt");
		check(irq_t - sleep_t >= lo && irq_t - sleep_t <= hi, "transfer time");
		k = 0;
		do begin
			ahb(1'b0, dt_pkg::ADDR_STATUS, 32'h0);
			k++;
		end while (d[5] !== 1'b1 && k < 1000);
		check(d[16:8] === 9'h001 && d[3] === 1'b0, "state after transfer");
		ahb(1'b1, dt_pkg::ADDR_STATUS, 32'h20);
	endtask
	task chk_gap(input int e);
		// Tick stays high at full speed, so count clock edges that see it
		repeat (3) @(posedge sys_clk iff tick === 1'b1);
		@(negedge sys_clk);
		check(gap == e, "cpu tick spacing");
	endtask
	task wake_up();
		int k;
		k = 0;
		wake <= 1'b1;
		while (halted !== 1'b0 && k < 400) begin
			@(posedge sys_clk);
			k++;
		end
		wake <= 1'b0;
		@(posedge sys_clk);
		check(k < 400, "no wake from sleep");
	endtask
	task end_sim();
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Longest path is a few thousand cycles; the margin covers slow polls
	initial begin
		#(30000 * 100);
		n_fail++;
		end_sim();
	end
	// ==========================================
	// Tests
	int n0;
	initial begin
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		rd_chk(dt_pkg::ADDR_COND_CODE, 32'h80);
		rd_chk(dt_pkg::ADDR_STATUS, 32'h101);
		rd_chk(8'h20, 32'h0);
		ahb(1'b1, dt_pkg::ADDR_COND_CODE, 32'h0);
		ahb(1'b1, dt_pkg::ADDR_INT_EN_TWO, 32'h1);
		n0 = n_irq;
		sleep_n(20);
		rd_chk(dt_pkg::ADDR_STATUS, 32'h2009);
		wake_up();
		check(n_irq == n0, "interrupt without direct transfer");
		ahb(1'b1, dt_pkg::ADDR_CTL_TWO, 32'h06);
		trans(dt_pkg::SPD_MED, 3, 8);
		chk_gap(8);
		ahb(1'b1, dt_pkg::ADDR_CTL_TWO, 32'h04);
		trans(dt_pkg::SPD_HIGH, 16, 40);
		chk_gap(1);
		ahb(1'b1, dt_pkg::ADDR_CTL_ONE, 32'h88);
		ahb(1'b1, dt_pkg::ADDR_TIMER_MODE, 32'h08);
		trans(dt_pkg::SPD_SUB, 3, 8);
		for (int s = 0; s < 3; s++) begin
			ahb(1'b1, dt_pkg::ADDR_CTL_TWO, 32'h04 | (s << 3));
			chk_gap(128 >> s);
		end
		ahb(1'b1, dt_pkg::ADDR_CTL_ONE, 32'h80);
		trans(dt_pkg::SPD_HIGH, 120, 200);
		ahb(1'b1, dt_pkg::ADDR_CTL_ONE, 32'h88);
		trans(dt_pkg::SPD_SUB, 3, 8);
		ahb(1'b1, dt_pkg::ADDR_CTL_ONE, 32'h90);
		ahb(1'b1, dt_pkg::ADDR_CTL_TWO, 32'h16);
		trans(dt_pkg::SPD_MED, 90, 160);
		ahb(1'b1, dt_pkg::ADDR_INT_EN_TWO, 32'h0);
		ahb(1'b1, dt_pkg::ADDR_CTL_ONE, 32'h00);
		ahb(1'b1, dt_pkg::ADDR_CTL_TWO, 32'h14);
		n0 = n_irq;
		sleep_n(30);
		rd_chk(dt_pkg::ADDR_STATUS, 32'h200A);
		wake_up();
		check(n_irq == n0 && spd === dt_pkg::SPD_HIGH, "masked transfer completed");
		ahb(1'b1, dt_pkg::ADDR_INT_EN_TWO, 32'h1);
		ahb(1'b1, dt_pkg::ADDR_COND_CODE, 32'h80);
		ahb(1'b1, dt_pkg::ADDR_CTL_TWO, 32'h06);
		sleep_n(30);
		ahb(1'b0, dt_pkg::ADDR_STATUS, 32'h0);
		check(d[4] === 1'b1 && d[16:8] === 9'h020, "locked sleep");
		wake <= 1'b1;
		repeat (100) @(posedge sys_clk);
		check(halted === 1'b1 && n_irq == n0, "locked mode left by interrupt");
		wake <= 1'b0;
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		check(halted === 1'b0 && spd === dt_pkg::SPD_HIGH, "outputs in reset");
		reset_n <= 1'b1;
		@(posedge sys_clk);
		rd_chk(dt_pkg::ADDR_STATUS, 32'h101);
		end_sim();
	end
endmodule

// *** src/direct_mode_transfer_control.sv ***
// Power-mode controller for direct transfers among the three executing speeds,
// with its control bits behind an AHB-Lite slave.
// Assumes the CPU pulses sleep_exec_in for one cycle when it executes a sleep
// instruction, and wake_irq_in is an already enabled interrupt request.
//
// Notes on behaviour
// - A sleep with direct transfer enabled changes speed and raises the transfer interrupt in the same cycle.
// - With the transfer interrupt disabled the block falls into sleep or watch instead.
// - A transfer tried with the global mask set falls into sleep or watch that no interrupt ends.
// - High speed with standby 0, low 0, medium 1 goes to medium speed through sleep.
// - Medium speed with standby 0, low 0, medium 0 goes to high speed through sleep.
// - Either active speed with standby 1, low 1, watch 1 goes to subactive through watch.
// - Subactive with standby 1, low 0, medium 0, watch 1 goes to high speed after the wait.
// - The same with medium 1 goes to medium speed after the oscillator wait.
// - Sleep and internal states count at the old rate, exception states at the new rate.
// - From subactive the oscillator wait from the select bits counts in system clocks.
// - Subactive runs the CPU at the watch rate divided by 2, 4 or 8.
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module direct_mode_transfer_control #(
	parameter int unsigned OSC_WAIT_STATES = 8192
) (
	input  wire logic        sys_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hwdata_in,
	output logic [31:0]      hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	input  wire logic        sleep_exec_in,
	input  wire logic        wake_irq_in,
	output logic [2:0]       speed_mode_out,
	output logic             cpu_halted_out,
	output logic             cpu_tick_out,
	output logic             dt_irq_out
);
	localparam int CW = dt_pkg::CNT_W;

	// ==========================================
	// Bus slave
	logic [7:0]  ctl_one;
	logic [7:0]  ctl_two;
	logic [7:0]  timer_mode;
	logic [7:0]  int_en_two;
	logic [7:0]  cond_code;
	logic        done_flag;
	logic        wr_pend;
	logic        rd_phase;
	logic [7:0]  addr_q;
	logic [31:0] hrdata;
	logic [7:0]  next_ctl_one;
	logic [7:0]  next_ctl_two;
	logic [7:0]  next_timer_mode;
	logic [7:0]  next_int_en_two;
	logic [7:0]  next_cond_code;
	logic        next_done_flag;
	logic        next_wr_pend;
	logic        next_rd_phase;
	logic [7:0]  next_addr_q;
	logic [31:0] next_hrdata;
	logic        accept;
	logic        set_done;

	dt_pkg::state_t state;
	dt_pkg::state_t next_state;
	dt_pkg::speed_t speed;
	dt_pkg::speed_t next_speed;
	dt_pkg::speed_t target;
	dt_pkg::speed_t next_target;
	logic           locked;
	logic           next_locked;
	logic           dt_flag;
	logic           next_dt_flag;
	logic           irq;
	logic           next_irq;

	// Only whole-word single transfers; hsize is not checked.
	assign accept = hsel_in && htrans_in[1] && hready_in;

	always_comb begin
		next_ctl_one = ctl_one;
		next_ctl_two = ctl_two;
		next_timer_mode = timer_mode;
		next_int_en_two = int_en_two;
		next_cond_code = cond_code;
		next_wr_pend = accept && hwrite_in;
		next_rd_phase = accept && !hwrite_in;
		next_addr_q = accept ? haddr_in[7:0] : addr_q;
		next_hrdata = hrdata;
		next_done_flag = done_flag;
		if (wr_pend) begin
			case (addr_q)
				dt_pkg::ADDR_CTL_ONE: next_ctl_one = hwdata_in[7:0];
				dt_pkg::ADDR_CTL_TWO: next_ctl_two = hwdata_in[7:0];
				dt_pkg::ADDR_TIMER_MODE: next_timer_mode = hwdata_in[7:0];
				dt_pkg::ADDR_INT_EN_TWO: next_int_en_two = hwdata_in[7:0];
				dt_pkg::ADDR_COND_CODE: next_cond_code = hwdata_in[7:0];
				dt_pkg::ADDR_STATUS: begin
					if (hwdata_in[dt_pkg::STAT_DONE_BIT]) begin
						next_done_flag = 1'b0;
					end
				end
				default: next_hrdata = hrdata;
			endcase
		end
		// A completion in the clearing cycle is kept
		if (set_done) begin
			next_done_flag = 1'b1;
		end
		// Read data is loaded in the single wait state of a read
		if (rd_phase) begin
			case (addr_q)
				dt_pkg::ADDR_CTL_ONE: next_hrdata = {24'h000000, ctl_one};
				dt_pkg::ADDR_CTL_TWO: next_hrdata = {24'h000000, ctl_two};
				dt_pkg::ADDR_TIMER_MODE: next_hrdata = {24'h000000, timer_mode};
				dt_pkg::ADDR_INT_EN_TWO: next_hrdata = {24'h000000, int_en_two};
				dt_pkg::ADDR_COND_CODE: next_hrdata = {24'h000000, cond_code};
				dt_pkg::ADDR_STATUS: begin
					next_hrdata = {15'h0000, state, 2'h0, done_flag, locked,
						cpu_halted_out, speed};
				end
				default: next_hrdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctl_one <= dt_pkg::CTL_ONE_RST;
			ctl_two <= dt_pkg::CTL_TWO_RST;
			timer_mode <= dt_pkg::TIMER_MODE_RST;
			int_en_two <= dt_pkg::INT_EN_TWO_RST;
			cond_code <= dt_pkg::COND_CODE_RST;
			done_flag <= 1'b0;
			wr_pend <= 1'b0;
			rd_phase <= 1'b0;
			addr_q <= 8'h00;
			hrdata <= 32'h00000000;
		end else begin
			ctl_one <= next_ctl_one;
			ctl_two <= next_ctl_two;
			timer_mode <= next_timer_mode;
			int_en_two <= next_int_en_two;
			cond_code <= next_cond_code;
			done_flag <= next_done_flag;
			wr_pend <= next_wr_pend;
			rd_phase <= next_rd_phase;
			addr_q <= next_addr_q;
			hrdata <= next_hrdata;
		end
	end

	assign hrdata_out = hrdata;
	assign hreadyout_out = !rd_phase;
	assign hresp_out = 1'b0;

	// ==========================================
	// Control bit decode
	logic       software_standby_select;
	logic       low_speed_select;
	logic       medium_speed_select;
	logic       direct_transfer_enable;
	logic       timer_watch_select;
	logic       ie_dt;
	logic       i_bit;
	logic [2:0] sts;
	logic [1:0] sa;
	logic       active;
	logic       dt_ok;
	logic       wake_ok;
	dt_pkg::speed_t mode_sel;

	assign software_standby_select = ctl_one[dt_pkg::CTL1_SOFTWARE_STANDBY_SELECT_BIT];
	assign low_speed_select = ctl_one[dt_pkg::CTL1_LOW_SPEED_SELECT_BIT];
	assign sts = ctl_one[dt_pkg::CTL1_STS_LSB +: 3];
	assign medium_speed_select = ctl_two[dt_pkg::CTL2_MEDIUM_SPEED_SELECT_BIT];
	assign direct_transfer_enable = ctl_two[dt_pkg::CTL2_DIRECT_TRANSFER_ENABLE_BIT];
	assign sa = ctl_two[dt_pkg::CTL2_SA_LSB +: 2];
	assign timer_watch_select = timer_mode[dt_pkg::TMR_WATCH_BIT];
	assign ie_dt = int_en_two[dt_pkg::IEN_DT_BIT];
	assign i_bit = cond_code[dt_pkg::CCR_I_BIT];
	assign active = (speed != dt_pkg::SPD_SUB);
	// A masked entry stays put whatever arrives later
	assign wake_ok = wake_irq_in && !locked;
	assign mode_sel = low_speed_select ? dt_pkg::SPD_SUB : (medium_speed_select ? dt_pkg::SPD_MED : dt_pkg::SPD_HIGH);

	assign dt_ok = (speed == dt_pkg::SPD_HIGH && !software_standby_select && !low_speed_select && medium_speed_select)
		|| (speed == dt_pkg::SPD_MED && !software_standby_select && !low_speed_select && !medium_speed_select)
		|| (active && software_standby_select && low_speed_select && timer_watch_select)
		|| (!active && software_standby_select && !low_speed_select && timer_watch_select);

	// ==========================================
	// CPU tick and state counter
	tick_if tk ();
	logic [7:0]    sub_div;
	logic          cnt_load;
	logic [CW-1:0] cnt_val;
	logic [CW-1:0] cnt_load_val;
	logic          cnt_step;
	logic          cnt_done;

	always_comb begin
		case (sa)
			2'h0: sub_div = dt_pkg::SUB_DIV_EIGHT;
			2'h1: sub_div = dt_pkg::SUB_DIV_FOUR;
			default: sub_div = dt_pkg::SUB_DIV_TWO;
		endcase
		case (speed)
			dt_pkg::SPD_MED: tk.period = dt_pkg::MED_DIV;
			dt_pkg::SPD_SUB: tk.period = 8'(dt_pkg::WATCH_DIV * sub_div);
			default: tk.period = 8'h01;
		endcase
	end

	// Restart keeps the first tick of a new rate a full period away
	assign tk.restart = (next_speed != speed);

	tick_gen u_tick (
		.sys_clk_in (sys_clk_in),
		.reset_n_in (reset_n_in),
		.tk         (tk.gen)
	);

	state_counter #(
		.W (CW)
	) u_count (
		.sys_clk_in  (sys_clk_in),
		.reset_n_in  (reset_n_in),
		.load_in     (cnt_load),
		.load_val_in (cnt_load_val),
		.step_in     (cnt_step),
		.count_out   (cnt_val),
		.done_out    (cnt_done)
	);

	// ==========================================
	// Mode state machine
	always_comb begin
		next_state = state;
		next_speed = speed;
		next_target = target;
		next_locked = locked;
		next_dt_flag = dt_flag;
		next_irq = 1'b0;
		cnt_load = 1'b0;
		cnt_load_val = dt_pkg::SLEEP_STATES + dt_pkg::INTERNAL_STATES;
		cnt_step = tk.tick;
		set_done = 1'b0;
		case (state)
			dt_pkg::ST_RUN: begin
				if (sleep_exec_in) begin
					cnt_load = 1'b1;
					next_locked = i_bit;
					next_dt_flag = 1'b0;
					if (direct_transfer_enable && dt_ok && ie_dt && !i_bit) begin
						next_dt_flag = 1'b1;
						next_target = mode_sel;
						next_state = software_standby_select ? dt_pkg::ST_DT_WATCH : dt_pkg::ST_DT_SLEEP;
					end else if (direct_transfer_enable && dt_ok) begin
						next_state = software_standby_select ? dt_pkg::ST_WATCH : dt_pkg::ST_SLEEP;
					end else if (software_standby_select && timer_watch_select) begin
						next_state = dt_pkg::ST_WATCH;
					end else if (software_standby_select) begin
						next_state = active ? dt_pkg::ST_STANDBY : dt_pkg::ST_WATCH;
					end else if (!active) begin
						next_state = dt_pkg::ST_SUBSLEEP;
					end else begin
						next_state = dt_pkg::ST_SLEEP;
					end
				end
			end
			dt_pkg::ST_DT_SLEEP, dt_pkg::ST_DT_WATCH: begin
				// Old rate still applies while these states count
				if (cnt_done) begin
					cnt_load = 1'b1;
					if (state == dt_pkg::ST_DT_WATCH && target != dt_pkg::SPD_SUB) begin
						next_state = dt_pkg::ST_OSC_WAIT;
						cnt_load_val = CW'(OSC_WAIT_STATES >> sts);
					end else begin
						next_state = dt_pkg::ST_DT_EXC;
						next_speed = target;
						next_irq = 1'b1;
						cnt_load_val = dt_pkg::EXC_STATES;
					end
				end
			end
			dt_pkg::ST_OSC_WAIT: begin
				cnt_step = 1'b1;
				if (cnt_done) begin
					next_speed = target;
					if (dt_flag) begin
						next_state = dt_pkg::ST_DT_EXC;
						next_irq = 1'b1;
						cnt_load = 1'b1;
						cnt_load_val = dt_pkg::EXC_STATES;
					end else begin
						next_state = dt_pkg::ST_RUN;
					end
				end
			end
			dt_pkg::ST_DT_EXC: begin
				// Ticks now run at the new rate
				if (cnt_done) begin
					next_state = dt_pkg::ST_RUN;
					next_dt_flag = 1'b0;
					set_done = 1'b1;
				end
			end
			dt_pkg::ST_SLEEP: begin
				if (wake_ok) begin
					next_state = dt_pkg::ST_RUN;
					next_speed = medium_speed_select ? dt_pkg::SPD_MED : dt_pkg::SPD_HIGH;
				end
			end
			dt_pkg::ST_SUBSLEEP: begin
				if (wake_ok) begin
					next_state = dt_pkg::ST_RUN;
				end
			end
			dt_pkg::ST_WATCH, dt_pkg::ST_STANDBY: begin
				if (wake_ok) begin
					next_target = mode_sel;
					if (mode_sel == dt_pkg::SPD_SUB) begin
						next_state = dt_pkg::ST_RUN;
						next_speed = dt_pkg::SPD_SUB;
					end else begin
						next_state = dt_pkg::ST_OSC_WAIT;
						cnt_load = 1'b1;
						cnt_load_val = CW'(OSC_WAIT_STATES >> sts);
					end
				end
			end
			default: next_state = dt_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= dt_pkg::ST_RUN;
			speed <= dt_pkg::SPD_HIGH;
			target <= dt_pkg::SPD_HIGH;
			locked <= 1'b0;
			dt_flag <= 1'b0;
			irq <= 1'b0;
		end else begin
			state <= next_state;
			speed <= next_speed;
			target <= next_target;
			locked <= next_locked;
			dt_flag <= next_dt_flag;
			irq <= next_irq;
		end
	end

	assign speed_mode_out = speed;
	assign cpu_halted_out = (state != dt_pkg::ST_RUN) && (state != dt_pkg::ST_DT_EXC);
	assign cpu_tick_out = tk.tick;
	assign dt_irq_out = irq;

	// ==========================================
	// Checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_sleep_run;
		state == dt_pkg::ST_RUN && sleep_exec_in;
	endsequence
	sequence s_dt_go;
		s_sleep_run and (direct_transfer_enable && dt_ok && ie_dt && !i_bit);
	endsequence

	a_dt_start: assert property (s_dt_go |=> dt_flag ##[1:300] dt_irq_out)
		else $error("direct transfer raised no interrupt");
	a_dt_masked: assert property ((s_sleep_run and (direct_transfer_enable && dt_ok && !ie_dt))
		|=> (state == dt_pkg::ST_SLEEP || state == dt_pkg::ST_WATCH) && !dt_irq_out)
		else $error("masked transfer did not fall asleep");
	a_ibit_lock: assert property (((state == dt_pkg::ST_WATCH || state == dt_pkg::ST_SLEEP)
		&& locked && wake_irq_in) |=> $stable(state))
		else $error("locked watch was left by an interrupt");
	a_high_med: assert property ((s_dt_go and speed == dt_pkg::SPD_HIGH && !software_standby_select)
		|=> state == dt_pkg::ST_DT_SLEEP && target == dt_pkg::SPD_MED)
		else $error("high to medium not taken through sleep");
	a_med_high: assert property ((s_dt_go and speed == dt_pkg::SPD_MED && !software_standby_select)
		|=> state == dt_pkg::ST_DT_SLEEP && target == dt_pkg::SPD_HIGH)
		else $error("medium to high not taken through sleep");
	a_active_sub: assert property ((s_dt_go and active && software_standby_select)
		|=> state == dt_pkg::ST_DT_WATCH && target == dt_pkg::SPD_SUB)
		else $error("active to subactive not taken through watch");
	a_sub_active: assert property ((s_dt_go and !active)
		|=> state == dt_pkg::ST_DT_WATCH && target == (medium_speed_select ? dt_pkg::SPD_MED : dt_pkg::SPD_HIGH))
		else $error("subactive transfer picked the wrong target");
	a_wait_to_exc: assert property ((state == dt_pkg::ST_OSC_WAIT && dt_flag && cnt_done)
		|=> state == dt_pkg::ST_DT_EXC && dt_irq_out && speed == target)
		else $error("oscillator wait did not lead to exception");
	a_exc_length: assert property ($rose(dt_irq_out)
		|-> cnt_val == dt_pkg::EXC_STATES && speed == target)
		else $error("exception states not loaded at the new rate");
	a_osc_length: assert property ((state != dt_pkg::ST_OSC_WAIT ##1
		state == dt_pkg::ST_OSC_WAIT) |-> cnt_val == CW'(OSC_WAIT_STATES >> sts))
		else $error("oscillator wait count wrong");
	a_sub_rate: assert property ((state == dt_pkg::ST_RUN && speed == dt_pkg::SPD_SUB
		&& sa[1] && tk.tick) |=> !tk.tick [*8])
		else $error("subactive tick too fast");
	a_plain_sleep: assert property ((s_sleep_run and !direct_transfer_enable)
		|=> !dt_flag && !dt_irq_out)
		else $error("plain sleep started a transfer");
endmodule

// *** src/dt_pkg.sv ***
// Constants, register map and state types for the direct mode transfer controller.
// Assumes one 10 MHz system clock; watch and subclock rates are derived from it.
package dt_pkg;
	// ==========================================
	// Register map, byte addresses
	localparam logic [7:0] ADDR_CTL_ONE    = 8'h00;
	localparam logic [7:0] ADDR_CTL_TWO    = 8'h04;
	localparam logic [7:0] ADDR_TIMER_MODE = 8'h08;
	localparam logic [7:0] ADDR_INT_EN_TWO = 8'h0C;
	localparam logic [7:0] ADDR_COND_CODE  = 8'h10;
	localparam logic [7:0] ADDR_STATUS     = 8'h14;
	// ==========================================
	// Field positions
	localparam int CTL1_SOFTWARE_STANDBY_SELECT_BIT = 7;
	localparam int CTL1_STS_LSB  = 4;
	localparam int CTL1_LOW_SPEED_SELECT_BIT = 3;
	localparam int CTL2_SA_LSB   = 3;
	localparam int CTL2_DIRECT_TRANSFER_ENABLE_BIT = 2;
	localparam int CTL2_MEDIUM_SPEED_SELECT_BIT = 1;
	localparam int TMR_WATCH_BIT = 3;
	localparam int IEN_DT_BIT    = 0;
	localparam int CCR_I_BIT     = 7;
	localparam int STAT_DONE_BIT = 5;
	// ==========================================
	// Values after reset
	localparam logic [7:0] CTL_ONE_RST    = 8'h00;
	localparam logic [7:0] CTL_TWO_RST    = 8'h00;
	localparam logic [7:0] TIMER_MODE_RST = 8'h00;
	localparam logic [7:0] INT_EN_TWO_RST = 8'h00;
	localparam logic [7:0] COND_CODE_RST  = 8'h80;
	// ==========================================
	// State counts and clock ratios
	localparam int          CNT_W           = 20;
	localparam logic [19:0] SLEEP_STATES    = 20'h00002;
	localparam logic [19:0] INTERNAL_STATES = 20'h00001;
	localparam logic [19:0] EXC_STATES      = 20'h0000E;
	localparam logic [7:0]  MED_DIV         = 8'h08;
	localparam logic [7:0]  WATCH_DIV       = 8'h10;
	localparam logic [7:0]  SUB_DIV_TWO     = 8'h02;
	localparam logic [7:0]  SUB_DIV_FOUR    = 8'h04;
	localparam logic [7:0]  SUB_DIV_EIGHT   = 8'h08;
	// ==========================================
	// Types
	typedef enum logic [8:0] {
		ST_RUN      = 9'h001,
		ST_DT_SLEEP = 9'h002,
		ST_DT_WATCH = 9'h004,
		ST_OSC_WAIT = 9'h008,
		ST_DT_EXC   = 9'h010,
		ST_SLEEP    = 9'h020,
		ST_WATCH    = 9'h040,
		ST_STANDBY  = 9'h080,
		ST_SUBSLEEP = 9'h100
	} state_t;
	typedef enum logic [2:0] {
		SPD_HIGH = 3'h1,
		SPD_MED  = 3'h2,
		SPD_SUB  = 3'h4
	} speed_t;
endpackage

// *** src/state_counter.sv ***
// Loadable down counter of states; done is high while the count is zero.
// Assumes load and step come from logic on the same clock.
`timescale 1ns/1ps
module state_counter #(
	parameter int W = 20
) (
	input  wire logic         sys_clk_in,
	input  wire logic         reset_n_in,
	input  wire logic         load_in,
	input  wire logic [W-1:0] load_val_in,
	input  wire logic         step_in,
	output logic [W-1:0]      count_out,
	output logic              done_out
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;

	always_comb begin
		next_count = count;
		if (load_in) begin
			next_count = load_val_in;
		end else if (step_in && count != '0) begin
			next_count = count - W'(1);
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign count_out = count;
	assign done_out = (count == '0);
endmodule

// *** src/tick_gen.sv ***
// CPU clock-enable generator: one tick every period system clocks.
// Assumes period is at least one; restart is pulsed on a speed change, not on a change of sa.
`timescale 1ns/1ps
module tick_gen (
	input  wire logic sys_clk_in,
	input  wire logic reset_n_in,
	tick_if.gen       tk
);
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic       tick;
	logic       next_tick;

	always_comb begin
		next_cnt = cnt + 8'h01;
		next_tick = 1'b0;
		if (tk.restart) begin
			next_cnt = 8'h00;
		end else if (cnt >= tk.period - 8'h01) begin
			next_cnt = 8'h00;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt <= 8'h00;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end

	assign tk.tick = tick;
endmodule

// *** src/tick_if.sv ***
// Period request and CPU tick between the controller and its tick generator.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
interface tick_if;
	logic [7:0] period;
	logic       restart;
	logic       tick;
	modport gen (input period, input restart, output tick);
	modport user (output period, output restart, input tick);
endinterface
